// file: itm_pkg.sv
// shared constants, register map and decode helpers of the interval timer
package itm_pkg;
   localparam int ITM_ADDR_W = 6;
   localparam int ITM_CNT_W = 16;
   localparam int ITM_PRE_W = 4;

   localparam logic [5:0] ITM_OFS_CTRL = 6'h00;
   localparam logic [5:0] ITM_OFS_MOD = 6'h04;
   localparam logic [5:0] ITM_OFS_CNT = 6'h08;

   localparam int ITM_BIT_EN = 0;
   localparam int ITM_BIT_RLD = 1;
   localparam int ITM_BIT_FLAG = 2;
   localparam int ITM_BIT_IE = 3;
   localparam int ITM_BIT_OVW = 4;
   localparam int ITM_BIT_DBG = 5;
   localparam int ITM_PRE_LSB = 8;

   localparam logic [15:0] ITM_CTRL_RST = 16'h0000;
   localparam logic [15:0] ITM_MOD_RST = 16'hFFFF;
   localparam logic [15:0] ITM_CNT_RST = 16'hFFFF;
   localparam logic [15:0] ITM_PRESC_RST = 16'hFFFF;
   localparam logic [3:0] ITM_PRE_RST = 4'h0;

   typedef enum logic [1:0] {
      ITM_SEL_CTRL,
      ITM_SEL_MOD,
      ITM_SEL_CNT,
      ITM_SEL_NONE
   } itm_sel_e;

   typedef enum logic {
      ITM_ST_IDLE,
      ITM_ST_ANSWER
   } itm_apb_st_e;

   // word-aligned decode; anything else inside the space is reserved
   function automatic itm_sel_e itm_decode(input logic [ITM_ADDR_W-1:0] addr);
      itm_sel_e sel;
      sel = ITM_SEL_NONE;
      if (addr == ITM_OFS_CTRL) begin
         sel = ITM_SEL_CTRL;
      end else if (addr == ITM_OFS_MOD) begin
         sel = ITM_SEL_MOD;
      end else if (addr == ITM_OFS_CNT) begin
         sel = ITM_SEL_CNT;
      end
      return sel;
   endfunction

   // control and modulus are privileged, the count may be read by user code
   function automatic logic itm_supv_only(input itm_sel_e sel);
      return (sel == ITM_SEL_CTRL) || (sel == ITM_SEL_MOD);
   endfunction
endpackage

// file: itm_prescaler.sv
// power-of-two prescaler producing counting ticks
`timescale 1ns/1ps
module itm_prescaler #(
   parameter int PRE_W = itm_pkg::ITM_PRE_W,
   parameter int DIV_W = 16
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_run,
   input wire logic i_clear,
   input wire logic [PRE_W-1:0] i_pre,
   output logic o_tick
);
   logic [DIV_W-1:0] presc_r;
   logic [DIV_W-1:0] mask;

   // low pre bits all zero marks the end of a 2**pre period
   function automatic logic [DIV_W-1:0] low_mask(input logic [PRE_W-1:0] pre);
      logic [DIV_W:0] one_hot;
      one_hot = '0;
      one_hot[pre] = 1'b1;
      return one_hot[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
   endfunction

   assign mask = low_mask(i_pre);
   assign o_tick = i_run && ((presc_r & mask) == '0);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         presc_r <= itm_pkg::ITM_PRESC_RST;
      end else if (i_clear) begin
         presc_r <= itm_pkg::ITM_PRESC_RST;
      end else if (i_run) begin
         presc_r <= presc_r - {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

// file: itm_down_counter.sv
// 16-bit down counter with reload, rollover and immediate load
`timescale 1ns/1ps
module itm_down_counter #(
   parameter int CNT_W = itm_pkg::ITM_CNT_W
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_tick,
   input wire logic i_load,
   input wire logic [CNT_W-1:0] i_load_val,
   input wire logic i_reload_mode,
   input wire logic [CNT_W-1:0] i_modulus,
   output logic [CNT_W-1:0] o_count,
   output logic o_timeout,
   output logic o_reloaded
);
   logic [CNT_W-1:0] cnt_r;
   logic at_zero;

   assign at_zero = (cnt_r == '0);
   assign o_timeout = i_tick && at_zero && !i_load;
   assign o_reloaded = o_timeout && i_reload_mode;
   assign o_count = cnt_r;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         cnt_r <= itm_pkg::ITM_CNT_RST;
      end else if (i_load) begin
         cnt_r <= i_load_val;
      end else if (i_tick) begin
         if (at_zero && i_reload_mode) begin
            cnt_r <= i_modulus;
         end else if (at_zero) begin
            cnt_r <= '1;
         end else begin
            cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// file: itm_interval_timer.sv
// interval timer top: apb register slave, control state and counting core
`timescale 1ns/1ps

module itm_interval_timer #(
   parameter int CNT_W = itm_pkg::ITM_CNT_W,
   parameter int PRE_W = itm_pkg::ITM_PRE_W
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [itm_pkg::ITM_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [2:0] i_pprot,
   input wire logic i_debug_mode,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_timeout_irq
);
   // apb slave state
   itm_pkg::itm_apb_st_e st_r;
   itm_pkg::itm_apb_st_e st_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic pready_r;
   logic irq_r;

   // control fields
   logic en_r;
   logic rld_r;
   logic flag_r;
   logic flag_nxt;
   logic ie_r;
   logic ovw_r;
   logic dbg_r;
   logic [PRE_W-1:0] pre_r;
   logic [CNT_W-1:0] mod_r;

   // decode and access qualification
   itm_pkg::itm_sel_e sel;
   logic user_mode;
   logic refused;
   logic access_start;
   logic access_done;
   logic wr_ok;
   logic wr_ctrl;
   logic wr_mod;
   logic [15:0] wdata16;
   logic [15:0] wmask16;
   logic [15:0] ctrl_view;

   // timing core
   logic frozen;
   logic run;
   logic tick;
   logic cnt_load;
   logic timeout;
   logic reloaded;
   logic pre_change;
   logic presc_clear;
   logic [PRE_W-1:0] pre_new;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] mod_new;

   // merge write data into a 16-bit field under the byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [15:0] mask);
      return (old_v & ~mask) | (new_v & mask);
   endfunction

   assign sel = itm_pkg::itm_decode(i_paddr);
   assign user_mode = !i_pprot[0];
   assign refused = (sel == itm_pkg::ITM_SEL_NONE)
      || (user_mode && itm_pkg::itm_supv_only(sel));

   assign access_start = i_psel && i_penable && (st_r == itm_pkg::ITM_ST_IDLE);
   assign access_done = i_psel && i_penable && (st_r == itm_pkg::ITM_ST_ANSWER);

   // writes take effect only at the edge that completes the transfer
   assign wr_ok = access_done && i_pwrite && !pslverr_r;
   assign wr_ctrl = wr_ok && (sel == itm_pkg::ITM_SEL_CTRL);
   assign wr_mod = wr_ok && (sel == itm_pkg::ITM_SEL_MOD);

   assign wdata16 = i_pwdata[15:0];
   assign wmask16 = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

   assign ctrl_view = {
      4'h0,
      pre_r,
      2'b00,
      dbg_r,
      ovw_r,
      ie_r,
      flag_r,
      rld_r,
      en_r
   };

   // apb answer state machine: one wait state, then pready for one cycle
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         itm_pkg::ITM_ST_IDLE: begin
            if (access_start) begin
               st_nxt = itm_pkg::ITM_ST_ANSWER;
            end
         end
         itm_pkg::ITM_ST_ANSWER: begin
            st_nxt = itm_pkg::ITM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         st_r <= itm_pkg::ITM_ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= (st_nxt == itm_pkg::ITM_ST_ANSWER);
      end
   end

   // read data and error are captured at the start of the access phase
   always_comb begin
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      if (access_start) begin
         prdata_nxt = '0;
         pslverr_nxt = refused;
         if (!refused && !i_pwrite) begin
            unique case (sel)
               itm_pkg::ITM_SEL_CTRL: begin
                  prdata_nxt[15:0] = ctrl_view;
               end
               itm_pkg::ITM_SEL_MOD: begin
                  prdata_nxt[CNT_W-1:0] = mod_r;
               end
               itm_pkg::ITM_SEL_CNT: begin
                  prdata_nxt[CNT_W-1:0] = count;
               end
               itm_pkg::ITM_SEL_NONE: begin
                  prdata_nxt = '0;
               end
            endcase
         end
      end else if (access_done) begin
         prdata_nxt = '0;
         pslverr_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         prdata_r <= '0;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // control bits in the low byte
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         en_r <= itm_pkg::ITM_CTRL_RST[itm_pkg::ITM_BIT_EN];
         rld_r <= itm_pkg::ITM_CTRL_RST[itm_pkg::ITM_BIT_RLD];
         ie_r <= itm_pkg::ITM_CTRL_RST[itm_pkg::ITM_BIT_IE];
         ovw_r <= itm_pkg::ITM_CTRL_RST[itm_pkg::ITM_BIT_OVW];
         dbg_r <= itm_pkg::ITM_CTRL_RST[itm_pkg::ITM_BIT_DBG];
      end else if (wr_ctrl && i_pstrb[0]) begin
         en_r <= wdata16[itm_pkg::ITM_BIT_EN];
         rld_r <= wdata16[itm_pkg::ITM_BIT_RLD];
         ie_r <= wdata16[itm_pkg::ITM_BIT_IE];
         ovw_r <= wdata16[itm_pkg::ITM_BIT_OVW];
         dbg_r <= wdata16[itm_pkg::ITM_BIT_DBG];
      end
   end

   // prescale field in the high byte
   assign pre_new = wdata16[itm_pkg::ITM_PRE_LSB +: PRE_W];
   assign pre_change = wr_ctrl && i_pstrb[1] && (pre_new != pre_r);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         pre_r <= itm_pkg::ITM_PRE_RST;
      end else if (wr_ctrl && i_pstrb[1]) begin
         pre_r <= pre_new;
      end
   end

   // timeout flag: hardware set wins over a software clear in the same cycle
   always_comb begin
      flag_nxt = flag_r;
      if (wr_ctrl && i_pstrb[0] && wdata16[itm_pkg::ITM_BIT_FLAG]) begin
         flag_nxt = 1'b0;
      end
      if (wr_mod) begin
         flag_nxt = 1'b0;
      end
      if (timeout) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         flag_r <= itm_pkg::ITM_CTRL_RST[itm_pkg::ITM_BIT_FLAG];
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // modulus latch
   assign mod_new = merge16(mod_r, wdata16, wmask16);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         mod_r <= itm_pkg::ITM_MOD_RST;
      end else if (wr_mod) begin
         mod_r <= mod_new;
      end
   end

   // interrupt request level
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_nxt && ie_r;
      end
   end

   // counting is held while disabled or frozen by debug; state is kept
   assign frozen = i_debug_mode && dbg_r;
   assign run = en_r && !frozen;

   // immediate overwrite loads the counter even while stopped
   assign cnt_load = wr_mod && ovw_r;
   assign presc_clear = cnt_load || reloaded || pre_change;

   itm_prescaler #(
      .PRE_W(PRE_W),
      .DIV_W(CNT_W)
   ) u_prescaler (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_run(run),
      .i_clear(presc_clear),
      .i_pre(pre_r),
      .o_tick(tick)
   );

   itm_down_counter #(
      .CNT_W(CNT_W)
   ) u_counter (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_tick(tick),
      .i_load(cnt_load),
      .i_load_val(mod_new),
      .i_reload_mode(rld_r),
      .i_modulus(mod_r),
      .o_count(count),
      .o_timeout(timeout),
      .o_reloaded(reloaded)
   );

   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_timeout_irq = irq_r;
endmodule

// file: itm_interval_timer_monitor.sv
// bus and interrupt checks for the interval timer
`timescale 1ns/1ps
module itm_interval_timer_monitor (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [itm_pkg::ITM_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   input wire logic [2:0] i_pprot,
   input wire logic i_debug_mode,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic o_timeout_irq
);
   logic acc_first;
   logic wr_done;
   logic rsvd;
   logic clr_wr;
   assign acc_first = i_psel && i_penable && !o_pready;
   assign wr_done = i_psel && i_penable && o_pready && i_pwrite && i_pprot[0];
   assign rsvd = (i_paddr > 6'h08) || (i_paddr[1:0] != 2'b00);
   // a flag clear drops the request one edge later, an enable clear two edges later
   assign clr_wr = wr_done && (i_paddr == 6'h00 || i_paddr == 6'h04);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   property p_ready_lat;
      acc_first |=> o_pready;
   endproperty
   a_ready_lat: assert property (p_ready_lat) else $error("ready not one cycle after access");
   property p_ready_pulse;
      o_pready |=> !o_pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_rsvd_err;
      acc_first && rsvd |=> o_pslverr && (o_prdata == 32'h0000_0000);
   endproperty
   a_rsvd_err: assert property (p_rsvd_err) else $error("reserved access without error");
   property p_user_err;
      acc_first && !i_pprot[0] && (i_paddr == 6'h00 || i_paddr == 6'h04) |=> o_pslverr;
   endproperty
   a_user_err: assert property (p_user_err) else $error("user access without error");
   property p_cnt_ok;
      acc_first && (i_paddr == 6'h08) |=> !o_pslverr;
   endproperty
   a_cnt_ok: assert property (p_cnt_ok) else $error("count access ended in error");
   property p_upper_zero;
      o_pready |-> (o_prdata[31:16] == 16'h0000);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
   property p_ie_off;
      wr_done && (i_paddr == 6'h00) && i_pstrb[0] && !i_pwdata[3] |=> ##1 !o_timeout_irq;
   endproperty
   a_ie_off: assert property (p_ie_off) else $error("request with enable cleared");
   property p_irq_hold;
      $fell(o_timeout_irq) |-> $past(clr_wr, 1) || $past(clr_wr, 2);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("request dropped without clear");
endmodule

bind itm_interval_timer itm_interval_timer_monitor u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .i_pstrb(i_pstrb), .i_pprot(i_pprot), .i_debug_mode(i_debug_mode), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_timeout_irq(o_timeout_irq));

// file: tb_itm_interval_timer.sv
// self-checking bench for the interval timer
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: %h vs %h", $time, (g), (e)); end end
module tb_itm_interval_timer;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [5:0] i_paddr = 6'h00;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic [3:0] i_pstrb = 4'hF;
   logic [2:0] i_pprot = 3'h1;
   logic i_debug_mode = 1'b0;
   logic [31:0] o_prdata;
   logic o_pready;
   logic o_pslverr;
   logic o_timeout_irq;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int t1;
   logic [31:0] rd;
   logic er;
   logic [15:0] c0;
   always #5 i_mclk = ~i_mclk;
   always @(posedge i_mclk) cyc <= cyc + 1;
   itm_interval_timer dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .i_pprot(i_pprot),
      .i_debug_mode(i_debug_mode), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .o_timeout_irq(o_timeout_irq));
   task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d, input logic p);
      @(posedge i_mclk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= {16'h0000, d};
      i_pprot <= {2'b00, p};
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do @(posedge i_mclk); while (o_pready !== 1'b1);
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      acc(1'b1, a, d, 1'b1);
   endtask
   task automatic rchk(input logic [5:0] a, input logic [15:0] e);
      acc(1'b0, a, 16'h0000, 1'b1);
      `CHK(rd, {16'h0000, e});
      `CHK(er, 1'b0);
   endtask
   task automatic wait_irq(input logic l);
      while (o_timeout_irq !== l) @(posedge i_mclk);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      rchk(6'h00, 16'h0000);
      rchk(6'h04, 16'hFFFF);
      rchk(6'h08, 16'hFFFF);
      acc(1'b0, 6'h0C, 16'h0000, 1'b1);
      `CHK(er, 1'b1);
      acc(1'b1, 6'h01, 16'h0001, 1'b1);
      `CHK(er, 1'b1);
      rchk(6'h00, 16'h0000);
      acc(1'b1, 6'h00, 16'h003F, 1'b0);
      `CHK(er, 1'b1);
      rchk(6'h00, 16'h0000);
      acc(1'b1, 6'h08, 16'h1234, 1'b0);
      `CHK(er, 1'b0);
      rchk(6'h08, 16'hFFFF);
      wr(6'h00, 16'h0010);
      wr(6'h04, 16'h0005);
      rchk(6'h08, 16'h0005);
      wr(6'h00, 16'h0000);
      wr(6'h04, 16'h0007);
      rchk(6'h08, 16'h0005);
      rchk(6'h04, 16'h0007);
      // reload period for prescale codes 0 to 9, measured between two flag raises
      for (int p = 0; p < 10; p++) begin
         wr(6'h00, 16'h000F | (16'(p) << 8));
         wait_irq(1'b0);
         wait_irq(1'b1);
         t1 = cyc;
         wr(6'h00, 16'h000F | (16'(p) << 8));
         wait_irq(1'b0);
         wait_irq(1'b1);
         `CHK(cyc - t1, 8 << p);
      end
      wr(6'h00, 16'h090B);
      rchk(6'h00, 16'h090F);
      wr(6'h04, 16'h0007);
      rchk(6'h00, 16'h090B);
      `CHK(o_timeout_irq, 1'b0);
      wr(6'h00, 16'h0003);
      repeat (20) @(posedge i_mclk);
      `CHK(o_timeout_irq, 1'b0);
      rchk(6'h00, 16'h0007);
      // enable the request while the flag stands, then take it away again
      wr(6'h00, 16'h000B);
      repeat (2) @(posedge i_mclk);
      `CHK(o_timeout_irq, 1'b1);
      wr(6'h00, 16'h0003);
      repeat (2) @(posedge i_mclk);
      `CHK(o_timeout_irq, 1'b0);
      wr(6'h00, 16'h0011);
      wr(6'h04, 16'h0003);
      repeat (4) @(posedge i_mclk);
      acc(1'b0, 6'h08, 16'h0000, 1'b0);
      `CHK(rd[15:0] > 16'hFFF0, 1'b1);
      wr(6'h00, 16'h0021);
      i_debug_mode <= 1'b1;
      acc(1'b0, 6'h08, 16'h0000, 1'b1);
      c0 = rd[15:0];
      rchk(6'h08, c0);
      wr(6'h04, 16'h0042);
      rchk(6'h04, 16'h0042);
      wr(6'h00, 16'h0001);
      acc(1'b0, 6'h08, 16'h0000, 1'b1);
      `CHK(rd[15:0] != c0, 1'b1);
      wr(6'h00, 16'h0000);
      acc(1'b0, 6'h08, 16'h0000, 1'b1);
      c0 = rd[15:0];
      rchk(6'h08, c0);
      conclude();
   end
   initial begin
      repeat (80000) @(posedge i_mclk);
      error_cnt++;
      conclude();
   end
endmodule
